// >>> logic/printer_port_pkg.sv
/*
  constants, field positions, timing counts and carrier types of the printer port.
  assumes a single 250 MHz clock; all times are converted to cycles here.
*/
package printer_port_pkg;

	localparam int CLK_MHZ = 250;

	// port register numbers on the register select lines
	localparam logic [2:0] REG_DATA    = 3'h0;
	localparam logic [2:0] REG_STATUS  = 3'h1;
	localparam logic [2:0] REG_CONTROL = 3'h2;

	// printer control write register fields, each bit set means active
	localparam int CTL_LATCH    = 0;
	localparam int CTL_AUTOFEED = 1;
	localparam int CTL_INIT     = 2;
	localparam int CTL_CHOOSE   = 3;
	localparam int CTL_IRQ_EN   = 4;
	localparam int CTL_DIR      = 5;
	localparam int CTL_W        = 6;
	localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;

	// printer status register fields
	localparam int ST_IRQ    = 2;
	localparam int ST_FAULT  = 3;
	localparam int ST_ONLINE = 4;
	localparam int ST_MEDIA  = 5;
	localparam int ST_DONE   = 6;
	localparam int ST_BUSY   = 7;

	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 8;

	// latch pulse timing around each byte
	localparam int SETUP_NS = 500;
	localparam int PULSE_NS = 1000;
	localparam int HOLD_NS  = 500;
	localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC  = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SETUP_CNT = 8'(SETUP_CYC - 1);
	localparam logic [7:0] PULSE_CNT = 8'(PULSE_CYC - 1);
	localparam logic [7:0] HOLD_CNT  = 8'(HOLD_CYC - 1);

	typedef struct packed {
		logic busy;
		logic transfer_done_n;
		logic media_exhausted;
		logic online;
		logic fault_n;
	} printer_status_t;

	localparam printer_status_t STATUS_IDLE = 5'h0b;

	typedef enum logic [2:0] {
		S_IDLE,
		S_SETUP,
		S_STROBE,
		S_HOLD,
		S_BUSY
	} seq_state_t;

endpackage

// >>> logic/printer_port_host_interface.sv
/*
  printer port with its host bus decode, byte fifo and latch pulse sequencer.
  assumes host bus pins are synchronous to i_clk and that at most one chip
  select is low at a time; open-drain pull-ups and pad tristates are outside.
*/
// Behaviour
// - register select lines pick the port register, decoded on every access
// - a write strobe low loads the host byte into the selected register
// - a read strobe low drives the selected register onto the host data lines
// - the port answers reads and writes only while its chip select is low
// - bus driver enable is active while any selected port is being read
// - printer data lines float whenever pin drive enable is high
// - a latch pulse output tells the printer to capture the data lines
// - an auto linefeed output asks the printer to feed paper itself
// - a low-active reset request output starts printer initialization
// - a low-active choose output selects the attached printer
// - the printer interrupt is driven only while control bit 4 is set
// - first variant interrupt follows the acknowledge level, high on rise
// - second variant interrupt goes low on the acknowledge rising edge
// - second variant interrupt returns high when a status read ends
// - pin drive enable low makes data lines outputs, unless the second variant turnaround bit 5 is set
// - second variant reset and status reads leave the interrupt high
`timescale 1ns/1ps

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	output wire logic             o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output wire logic             o_out_valid,
	input  wire logic             i_out_ready,
	output wire logic [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;

	wire logic push = i_in_valid && o_in_ready;
	wire logic pop  = o_out_valid && i_out_ready;
	wire logic [PW-1:0] next_wr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
	wire logic [PW-1:0] next_rd = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;

	assign o_in_ready  = (count != FULL_COUNT);
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];

	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= next_wr;
			if (pop)
				rd_ptr <= next_rd;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

module printer_port_host_interface
	import printer_port_pkg::*;
#(
	parameter bit SECOND_VARIANT = 1'b0
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_printer_port_select_n,
	input  wire logic              i_serial_select_a_n,
	input  wire logic              i_serial_select_b_n,
	input  wire logic [2:0]        i_register_select_lines,
	input  wire logic              i_write_strobe_in_n,
	input  wire logic              i_read_strobe_in_n,
	input  wire logic [DATA_W-1:0] i_host_data_lines,
	output logic      [DATA_W-1:0] o_host_data_lines,
	output logic                   o_host_data_oe,
	output logic                   o_bus_driver_enable,
	output logic                   o_write_ready,
	input  wire logic              i_pin_drive_enable,
	input  wire logic [DATA_W-1:0] i_printer_data_lines,
	output logic      [DATA_W-1:0] o_printer_data_lines,
	output logic                   o_printer_data_oe,
	output logic                   o_latch_pulse_n,
	output logic                   o_auto_linefeed_n,
	output logic                   o_printer_reset_n,
	output logic                   o_printer_choose_n,
	output logic                   o_printer_irq,
	output logic                   o_printer_irq_oe,
	input  wire logic              i_fault_n,
	input  wire logic              i_printer_online,
	input  wire logic              i_busy,
	input  wire logic              i_media_exhausted,
	input  wire logic              i_transfer_done_n
);
	logic            rst_meta;
	logic            rst_sync;
	printer_status_t stat_meta;
	printer_status_t stat;
	logic            done_prev;
	logic            wr_prev;
	logic            rd_prev;
	logic [CTL_W-1:0] ctrl;
	logic [DATA_W-1:0] pd_out;
	logic            irq_n;
	seq_state_t      state;
	seq_state_t      next_state;
	logic [7:0]      cnt;
	logic [7:0]      next_cnt;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// printer inputs are asynchronous to us whatever the host side does
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			stat_meta <= STATUS_IDLE;
			stat      <= STATUS_IDLE;
		end else begin
			stat_meta <= {i_busy, i_transfer_done_n, i_media_exhausted,
				i_printer_online, i_fault_n};
			stat      <= stat_meta;
		end
	end

	// host decode
	wire logic port_sel   = !i_printer_port_select_n;
	wire logic any_sel    = port_sel || !i_serial_select_a_n || !i_serial_select_b_n;
	wire logic sel_data   = port_sel && (i_register_select_lines == REG_DATA);
	wire logic sel_status = port_sel && (i_register_select_lines == REG_STATUS);
	wire logic sel_ctrl   = port_sel && (i_register_select_lines == REG_CONTROL);
	// one write per strobe: act on the falling edge, not on every low cycle
	wire logic wr_take    = !i_write_strobe_in_n && wr_prev;
	wire logic rd_active  = port_sel && !i_read_strobe_in_n;
	wire logic status_end = sel_status && i_read_strobe_in_n && !rd_prev;
	wire logic ack_rise   = stat.transfer_done_n && !done_prev;

	wire logic fifo_push  = wr_take && sel_data;
	wire logic fifo_ready;
	wire logic fifo_valid;
	wire logic [DATA_W-1:0] fifo_data;
	wire logic fifo_pop   = (state == S_IDLE);

	wire logic [DATA_W-1:0] status_word = {stat.busy, stat.transfer_done_n,
		stat.media_exhausted, stat.online, stat.fault_n, o_printer_irq, 2'b00};
	wire logic [DATA_W-1:0] ctrl_word = {2'b00, ctrl};
	wire logic [DATA_W-1:0] data_word = o_printer_data_oe ? pd_out : i_printer_data_lines;
	wire logic [DATA_W-1:0] rd_mux = sel_data ? data_word :
		sel_status ? status_word :
		sel_ctrl ? ctrl_word : '0;

	wire logic drive_pd = !i_pin_drive_enable &&
		!(SECOND_VARIANT && ctrl[CTL_DIR]);
	wire logic seq_strobe = (state == S_STROBE);

	byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) data_fifo (
		.i_clk      (i_clk),
		.i_rst_n    (rst_sync),
		.i_in_valid (fifo_push),
		.o_in_ready (fifo_ready),
		.i_in_data  (i_host_data_lines),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data (fifo_data)
	);

	// byte sequencer: setup, latch pulse, hold, then wait out printer busy
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			S_IDLE: begin
				if (fifo_valid) begin
					next_state = S_SETUP;
					next_cnt   = SETUP_CNT;
				end
			end
			S_SETUP: begin
				if (cnt == '0) begin
					next_state = S_STROBE;
					next_cnt   = PULSE_CNT;
				end else
					next_cnt = cnt - 1'b1;
			end
			S_STROBE: begin
				if (cnt == '0) begin
					next_state = S_HOLD;
					next_cnt   = HOLD_CNT;
				end else
					next_cnt = cnt - 1'b1;
			end
			S_HOLD: begin
				if (cnt == '0)
					next_state = S_BUSY;
				else
					next_cnt = cnt - 1'b1;
			end
			S_BUSY: begin
				if (!stat.busy)
					next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			state  <= S_IDLE;
			cnt    <= '0;
			pd_out <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			if (fifo_pop && fifo_valid)
				pd_out <= fifo_data;
		end
	end

	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			wr_prev   <= 1'b1;
			rd_prev   <= 1'b1;
			done_prev <= 1'b1;
			ctrl      <= CTL_RESET;
		end else begin
			wr_prev   <= i_write_strobe_in_n;
			rd_prev   <= i_read_strobe_in_n;
			done_prev <= stat.transfer_done_n;
			if (wr_take && sel_ctrl)
				ctrl <= i_host_data_lines[CTL_W-1:0];
		end
	end

	// second variant flag; the edge that sets it beats a clearing read end
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync)
			irq_n <= 1'b1;
		else if (ack_rise)
			irq_n <= 1'b0;
		else if (status_end)
			irq_n <= 1'b1;
	end

	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			o_host_data_lines    <= '0;
			o_host_data_oe       <= 1'b0;
			o_bus_driver_enable  <= 1'b0;
			o_write_ready        <= 1'b0;
			o_printer_data_lines <= '0;
			o_printer_data_oe    <= 1'b0;
			o_latch_pulse_n      <= 1'b1;
			o_auto_linefeed_n    <= 1'b1;
			o_printer_reset_n    <= 1'b1;
			o_printer_choose_n   <= 1'b1;
			o_printer_irq        <= SECOND_VARIANT;
			o_printer_irq_oe     <= 1'b0;
		end else begin
			o_host_data_lines    <= rd_mux;
			o_host_data_oe       <= rd_active;
			o_bus_driver_enable  <= any_sel && !i_read_strobe_in_n;
			o_write_ready        <= fifo_ready;
			o_printer_data_lines <= pd_out;
			o_printer_data_oe    <= drive_pd;
			o_latch_pulse_n      <= !(seq_strobe || ctrl[CTL_LATCH]);
			o_auto_linefeed_n    <= !ctrl[CTL_AUTOFEED];
			o_printer_reset_n    <= !ctrl[CTL_INIT];
			o_printer_choose_n   <= !ctrl[CTL_CHOOSE];
			o_printer_irq        <= SECOND_VARIANT ? irq_n : stat.transfer_done_n;
			o_printer_irq_oe     <= ctrl[CTL_IRQ_EN];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_sync);

	sequence s_ack_rise;
		$rose(stat.transfer_done_n);
	endsequence

	sequence s_status_end;
		sel_status ##1 (sel_status && !i_read_strobe_in_n) ##1 (sel_status && i_read_strobe_in_n);
	endsequence

	property p_port_only_when_selected;
		o_host_data_oe |-> $past(port_sel);
	endproperty
	a_port_only_when_selected: assert property (p_port_only_when_selected)
		else $error("host data driven without port select");

	property p_read_drives;
		(port_sel && !i_read_strobe_in_n && sel_status) |=> (o_host_data_oe && o_host_data_lines[ST_BUSY] == $past(stat.busy));
	endproperty
	a_read_drives: assert property (p_read_drives)
		else $error("status read not presented on host bus");

	property p_bus_driver;
		(!i_read_strobe_in_n && !i_serial_select_a_n) |=> o_bus_driver_enable;
	endproperty
	a_bus_driver: assert property (p_bus_driver)
		else $error("bus driver enable missing on serial read");

	property p_float;
		i_pin_drive_enable |=> !o_printer_data_oe;
	endproperty
	a_float: assert property (p_float)
		else $error("printer data driven while pin drive enable high");

	property p_irq_gate;
		!ctrl[CTL_IRQ_EN] |=> !o_printer_irq_oe;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("printer interrupt driven while disabled");

	property p_irq_follow;
		(s_ack_rise and (!SECOND_VARIANT)) |=>
			o_printer_irq ##1 (o_printer_irq || !stat.transfer_done_n);
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("first variant interrupt not high after acknowledge rise");

	property p_irq_set;
		(s_ack_rise and SECOND_VARIANT) |=> ##1 !o_printer_irq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("second variant interrupt not low after acknowledge rise");

	property p_irq_clear;
		((s_status_end ##0 !ack_rise) and SECOND_VARIANT) |=> irq_n ##1 o_printer_irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("status read did not clear the interrupt");

	property p_latch;
		(state == S_SETUP && cnt == '0) |=> ##1 !o_latch_pulse_n [*8];
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch pulse not asserted after setup");

	property p_ctrl_write;
		(wr_take && sel_ctrl) |=> ##1 (o_printer_choose_n == !$past(i_host_data_lines[CTL_CHOOSE], 2));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write did not reach choose output");

endmodule

// >>> tb/line_printer_model.sv
/*
  behavioural line printer on the far side of the printer port.
  assumes low-active latch pulse and the data wire as seen on the pins.
*/
`timescale 1ns/1ps

module line_printer_model (
	input  wire logic       i_clk,
	input  wire logic       i_latch_n,
	input  wire logic [7:0] i_data,
	input  wire logic       i_slow,
	input  wire logic       i_err_n,
	input  wire logic       i_online,
	input  wire logic       i_no_paper,
	output logic            o_fault_n,
	output logic            o_online,
	output logic            o_busy,
	output logic            o_media_exhausted,
	output logic            o_transfer_done_n,
	output logic            o_got,
	output logic      [7:0] o_byte
);
	// paper out also counts as an error
	assign o_fault_n = i_err_n & ~i_no_paper;
	assign o_online = i_online;
	assign o_media_exhausted = i_no_paper;

	initial begin
		o_busy = 1'b0;
		o_transfer_done_n = 1'b1;
		o_got = 1'b0;
		o_byte = 8'h00;
		forever begin
			@(negedge i_latch_n);
			o_byte = i_data;
			o_got = 1'b1;
			o_busy = 1'b1;
			@(posedge i_latch_n);
			o_got = 1'b0;
			// slow mode keeps busy long enough to fill the port fifo
			// status lines move on the falling edge, clear of the port's sampling edge
			repeat (i_slow ? 400 : 20) @(negedge i_clk);
			o_transfer_done_n = 1'b0;
			repeat (10) @(negedge i_clk);
			o_transfer_done_n = 1'b1;
			o_busy = 1'b0;
		end
	end
endmodule

// >>> tb/printer_port_host_interface_test.sv
/*
  self-checking bench for the printer port; a second variant copy shares all inputs.
  assumes the line printer model drives the status lines and a single clock.
*/
`timescale 1ns/1ps

module printer_port_host_interface_test;
	import printer_port_pkg::*;

	logic            clk, rst_n, pps_n, ssa_n, ssb_n, wr_n, rd_n, pde, slow, err_n, onl, nop;
	logic      [2:0] addr;
	logic      [7:0] hdata, pad, b;
	logic      [5:0] ctl;
	logic            hoe_d;
	wire logic [7:0] pd_o, pd_wire, hd_o, gbyte;
	wire logic       hoe, bde, wrdy, pd_oe, latch_n, afd_n, prst_n, choose_n, irq, irq_oe;
	wire logic       fault_n, online, busy, media, done_n, got, irq2;
	int              fail_count, samples_checked, refused, seed;
	logic      [7:0] rd_q[$];
	logic      [7:0] pr_q[$];

	// data wire: the port drives it only while its enable is high
	assign pd_wire = pd_oe ? pd_o : pad;

	printer_port_host_interface #(.SECOND_VARIANT(1'b0)) i_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_printer_port_select_n(pps_n),
		.i_serial_select_a_n(ssa_n), .i_serial_select_b_n(ssb_n),
		.i_register_select_lines(addr), .i_write_strobe_in_n(wr_n),
		.i_read_strobe_in_n(rd_n), .i_host_data_lines(hdata), .o_host_data_lines(hd_o),
		.o_host_data_oe(hoe), .o_bus_driver_enable(bde), .o_write_ready(wrdy),
		.i_pin_drive_enable(pde), .i_printer_data_lines(pd_wire),
		.o_printer_data_lines(pd_o), .o_printer_data_oe(pd_oe), .o_latch_pulse_n(latch_n),
		.o_auto_linefeed_n(afd_n), .o_printer_reset_n(prst_n), .o_printer_choose_n(choose_n),
		.o_printer_irq(irq), .o_printer_irq_oe(irq_oe), .i_fault_n(fault_n),
		.i_printer_online(online), .i_busy(busy), .i_media_exhausted(media),
		.i_transfer_done_n(done_n)
	);

	line_printer_model i_printer (
		.i_clk(clk), .i_latch_n(latch_n), .i_data(pd_wire), .i_slow(slow),
		.i_err_n(err_n), .i_online(onl), .i_no_paper(nop), .o_fault_n(fault_n),
		.o_online(online), .o_busy(busy), .o_media_exhausted(media),
		.o_transfer_done_n(done_n), .o_got(got), .o_byte(gbyte)
	);

	// second variant shares every input; only its interrupt is watched
	printer_port_host_interface #(.SECOND_VARIANT(1'b1)) i_dut_v2 (
		.i_clk(clk), .i_rst_n(rst_n), .i_printer_port_select_n(pps_n),
		.i_serial_select_a_n(ssa_n), .i_serial_select_b_n(ssb_n),
		.i_register_select_lines(addr), .i_write_strobe_in_n(wr_n),
		.i_read_strobe_in_n(rd_n), .i_host_data_lines(hdata), .o_host_data_lines(),
		.o_host_data_oe(), .o_bus_driver_enable(), .o_write_ready(),
		.i_pin_drive_enable(pde), .i_printer_data_lines(pd_wire),
		.o_printer_data_lines(), .o_printer_data_oe(), .o_latch_pulse_n(),
		.o_auto_linefeed_n(), .o_printer_reset_n(), .o_printer_choose_n(),
		.o_printer_irq(irq2), .o_printer_irq_oe(), .i_fault_n(fault_n),
		.i_printer_online(online), .i_busy(busy), .i_media_exhausted(media),
		.i_transfer_done_n(done_n)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic hwrite(input logic sel_n, input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		pps_n = sel_n;
		addr = a;
		hdata = d;
		wr_n = 1'b0;
		@(negedge clk);
		wr_n = 1'b1;
		pps_n = 1'b1;
		@(negedge clk);
	endtask

	task automatic hread(input logic [2:0] a, input logic [7:0] exp);
		@(negedge clk);
		rd_q.push_back(exp);
		pps_n = 1'b0;
		addr = a;
		rd_n = 1'b0;
		repeat (3) @(negedge clk);
		// select outlasts the strobe so the rising strobe edge still sees it
		rd_n = 1'b1;
		@(negedge clk);
		pps_n = 1'b1;
		@(negedge clk);
	endtask

	task automatic wait_drain;
		int n;
		for (n = 0; n < 20000 && (pr_q.size() != 0 || busy); n++)
			@(negedge clk);
		check(8'(n == 20000), 8'h00);
	endtask

	// read results: oldest note against each newly driven read
	always @(posedge clk) begin
		#1;
		if (hoe === 1'b1 && hoe_d !== 1'b1)
			check(hd_o, rd_q.size() ? rd_q.pop_front() : 8'hxx);
		hoe_d = hoe;
	end

	always @(posedge got)
		check(gbyte, pr_q.size() ? pr_q.pop_front() : 8'hxx);

	// interrupt follows the acknowledge level in this variant
	always @(negedge done_n) begin
		repeat (6) @(posedge clk);
		#1 check({7'h00, irq}, 8'h00);
	end

	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		end_sim();
	end

	initial begin
		{rst_n, pps_n, ssa_n, ssb_n, wr_n, rd_n} = 6'h1f;
		{pde, slow, err_n, onl, nop} = 5'h06;
		addr = 3'h0;
		hdata = 8'h00;
		pad = 8'h00;
		hoe_d = 1'b0;
		seed = $urandom(32'h0c2f);
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check({latch_n, afd_n, prst_n, choose_n, irq_oe, 3'h0}, 8'hf0);
		check({7'h00, irq2}, 8'h01);
		$display("test reset done");

		for (int i = 0; i < 6; i++) begin
			// latch bit stays clear: forcing it would fire a byte at the printer
			ctl = (i == 0) ? 6'h1e : (6'($urandom) & 6'h1e);
			hwrite(1'b0, REG_CONTROL, {2'h0, ctl});
			hread(REG_CONTROL, {2'h0, ctl});
			check({4'h0, afd_n, prst_n, choose_n, irq_oe}, {4'h0, ~ctl[CTL_AUTOFEED], ~ctl[CTL_INIT],
				~ctl[CTL_CHOOSE], ctl[CTL_IRQ_EN]});
		end
		hwrite(1'b0, REG_CONTROL, 8'h10);
		hwrite(1'b0, 3'h5, 8'hff);
		hread(3'h5, 8'h00);
		hwrite(1'b1, REG_CONTROL, 8'h0e);
		hread(REG_CONTROL, 8'h10);
		for (int j = 0; j < 2; j++) begin
			@(negedge clk);
			{ssb_n, ssa_n} = j ? 2'b01 : 2'b10;
			rd_n = 1'b0;
			repeat (2) @(negedge clk);
			check({6'h00, hoe, bde}, 8'h01);
			{ssb_n, ssa_n, rd_n} = 3'h7;
			repeat (2) @(negedge clk);
			check({7'h00, bde}, 8'h00);
		end
		$display("test host decode done");

		for (int i = 0; i < 3; i++) begin
			b = 8'($urandom);
			pr_q.push_back(b);
			hwrite(1'b0, REG_DATA, b);
		end
		wait_drain();
		check({7'h00, pd_oe}, 8'h01);
		repeat (6) @(negedge clk);
		check({7'h00, irq2}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			{err_n, onl, nop} = 3'($urandom);
			repeat (4) @(negedge clk);
			hread(REG_STATUS, {2'h1, nop, onl, err_n & ~nop, 3'h4});
		end
		{err_n, onl, nop} = 3'h6;
		check({7'h00, irq2}, 8'h01);
		$display("test bytes and status done");

		pde = 1'b1;
		pad = 8'($urandom);
		repeat (4) @(negedge clk);
		check({7'h00, pd_oe}, 8'h00);
		hread(REG_DATA, pad);
		pde = 1'b0;
		$display("test data direction done");

		// slow printer holds the sequencer so the fifo must refuse
		slow = 1'b1;
		refused = 0;
		for (int i = 0; i < 12; i++) begin
			b = 8'($urandom);
			repeat (3) @(negedge clk);
			if (wrdy === 1'b1)
				pr_q.push_back(b);
			else
				refused++;
			hwrite(1'b0, REG_DATA, b);
		end
		check(8'(refused != 0), 8'h01);
		wait_drain();
		$display("test fifo fill done");
		end_sim();
	end
endmodule
